//--- design/dword_shift_subtract_unit.sv
// Top: decode, shift, trapping subtract and exception flags of the doubleword unit
`timescale 1ns/100ps
// Summary of operation
// RQ1 - Left shift by operand A low six bits
// RQ2 - Left shift by thirty-two plus count field
// RQ3 - Arithmetic right shift by count field
// RQ4 - Arithmetic right shift by operand A bits
// RQ5 - Arithmetic right shift by thirty-two plus count
// RQ6 - Logical right shift by count field
// RQ7 - Logical right shift by operand A bits
// RQ8 - Logical right shift by thirty-two plus count
// RQ9 - Subtract operand B from operand A
// RQ10 - Overflow when carries from 62, 63 differ
// RQ11 - No write-back on overflow
// RQ12 - Reserved exception outside 64-bit or kernel mode
// RQ13 - Required zero fields must be zero
// RQ14 - No write-back on reserved exception
module dword_shift_subtract_unit (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire dword_unit_pkg::issue_s req,
  output dword_unit_pkg::answer_s     answer
);

  // ************************************************************
  // State and reset synchroniser
  // ************************************************************
  typedef struct packed {
    dword_unit_pkg::answer_s res;  // Registered answer
  } unit_state_s;

  unit_state_s state_reg;      // Current state
  unit_state_s state_next;     // Next state
  logic [1:0]  rst_pipe_reg;   // Release synchroniser
  logic        rst_sync_n;     // Synchronised reset, active low

  // Two-flop release of the asynchronous reset
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe_reg <= dword_unit_pkg::RST_PIPE_INIT;
    end else begin
      rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end
  end

  assign rst_sync_n = rst_pipe_reg[1];

  // ************************************************************
  // Field decode
  // ************************************************************
  logic [5:0]  opcode;     // Major opcode
  logic [5:0]  func;       // Function code
  logic [4:0]  a_idx;      // operand_a_index
  logic [4:0]  d_idx;      // Destination index
  logic [4:0]  shc;        // shift_count_field
  logic        is_fixed;   // Count from instruction
  logic        is_var;     // Count from operand A
  logic        is_sub;     // Trapping subtract
  logic        plus32;     // Count plus thirty-two
  logic        hit;        // Instruction belongs to this unit
  logic        legal;      // Mode allows execution
  logic        field_ok;   // Required-zero field is zero
  logic [5:0]  sh_amt;     // Shift amount
  logic        sh_right;   // Right shift
  logic        sh_arith;   // Sign fill
  logic [63:0] sh_result;  // Shifter output

  assign opcode = req.instr[dword_unit_pkg::OPC_MSB:dword_unit_pkg::OPC_LSB];
  assign func   = req.instr[dword_unit_pkg::FUNC_MSB:dword_unit_pkg::FUNC_LSB];
  assign a_idx  = req.instr[dword_unit_pkg::OPA_MSB:dword_unit_pkg::OPA_LSB];
  assign d_idx  = req.instr[dword_unit_pkg::DST_MSB:dword_unit_pkg::DST_LSB];
  assign shc    = req.instr[dword_unit_pkg::SHC_MSB:dword_unit_pkg::SHC_LSB];

  // Class of the function code
  assign plus32   = (func == dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_PLUS_THIRTYTWO)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_PLUS_THIRTYTWO)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_PLUS_THIRTYTWO);
  assign is_fixed = plus32
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_FIXED)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_FIXED);
  assign is_var   = (func == dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_BY_REG)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_BY_REG)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_BY_REG);
  assign is_sub   = (func == dword_unit_pkg::FN_DWORD_MINUS_WITH_TRAP);
  assign hit      = req.valid && (opcode == dword_unit_pkg::OPC_REG_GROUP)
                 && (is_fixed || is_var || is_sub);

  // Allowed in 64-bit mode or in kernel mode only [RQ12]
  assign legal    = req.mode64 || req.kernel;

  // Fixed forms need zero operand A index, the others a zero count field [RQ13]
  assign field_ok = is_fixed ? (a_idx == dword_unit_pkg::ZERO_FIELD)
                             : (shc == dword_unit_pkg::ZERO_FIELD);

  // ************************************************************
  // Shifter control
  // ************************************************************
  // Variable forms use operand A bits 5..0, fixed forms the count [RQ1] [RQ4] [RQ7]
  // A top bit of one adds thirty-two to the count [RQ2] [RQ5] [RQ8]
  assign sh_amt   = is_var ? req.a_val[dword_unit_pkg::VAR_AMT_MSB:0] : {plus32, shc};
  // Only the two left forms shift left [RQ1] [RQ2]
  assign sh_right = (func != dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_BY_REG)
                 && (func != dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_PLUS_THIRTYTWO);
  // Arithmetic forms replicate bit 63 [RQ3] [RQ4] [RQ5]
  assign sh_arith = (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_FIXED)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_BY_REG)
                 || (func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_PLUS_THIRTYTWO);

  // Shared barrel shifter for all eight shift forms
  dword_shifter #(
    .WIDTH (64)
  ) u_shifter (
    .data   (req.b_val),
    .amount (sh_amt),
    .right  (sh_right),
    .arith  (sh_arith),
    .result (sh_result)
  );

  // ************************************************************
  // Trapping subtract
  // ************************************************************
  logic [63:0] low_sum;   // Sum of bits 62..0, carry out in bit 63
  logic [64:0] full_sum;  // Full sum, carry out of bit 63 in bit 64
  logic [63:0] diff;      // Difference A minus B
  logic        ovf;       // Two's-complement overflow

  // A minus B as A plus inverted B plus one [RQ9]
  assign low_sum  = {1'b0, req.a_val[62:0]} + {1'b0, ~req.b_val[62:0]} + dword_unit_pkg::ONE64;
  assign full_sum = {1'b0, req.a_val} + {1'b0, ~req.b_val} + {1'b0, dword_unit_pkg::ONE64};
  assign diff     = full_sum[63:0];
  // Overflow when the two top carries disagree [RQ10]
  assign ovf      = low_sum[63] ^ full_sum[64];

  // ************************************************************
  // Next-state logic
  // ************************************************************
  // Answer one cycle after issue; exceptions block the write-back
  always_comb begin
    state_next             = state_reg;
    state_next.res.done    = 1'b0;
    state_next.res.wb_en   = 1'b0;
    state_next.res.ovf_exc = 1'b0;
    state_next.res.rsv_exc = 1'b0;
    if (hit) begin
      state_next.res.done     = 1'b1;
      state_next.res.wb_index = d_idx;
      if (!legal || !field_ok) begin
        // Reserved instruction: raise and write nothing [RQ12] [RQ13] [RQ14]
        state_next.res.rsv_exc = 1'b1;
      end else if (is_sub && ovf) begin
        // Overflow: raise and leave destination alone [RQ10] [RQ11]
        state_next.res.ovf_exc = 1'b1;
      end else if (is_sub) begin
        // Difference to destination [RQ9]
        state_next.res.wb_en   = 1'b1;
        state_next.res.wb_data = diff;
      end else begin
        // Shift result to destination [RQ1] [RQ3] [RQ6]
        state_next.res.wb_en   = 1'b1;
        state_next.res.wb_data = sh_result;
      end
    end
  end

  // State register
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state_reg.res <= dword_unit_pkg::ANSWER_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign answer = state_reg.res;

  // ************************************************************
  // Checks
  // ************************************************************
  dword_unit_pkg::issue_s q_req_reg;  // Issue of the previous cycle
  logic                   q_ok_reg;   // Previous issue was hit, legal, well formed
  logic [5:0]             q_func;     // Previous function code
  logic [5:0]             q_shc;      // Previous count field, zero-extended

  // Helper copy of the issue for result comparison
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      q_req_reg <= '0;
      q_ok_reg  <= 1'b0;
    end else begin
      q_req_reg <= req;
      q_ok_reg  <= hit && legal && field_ok;
    end
  end

  assign q_func = q_req_reg.instr[dword_unit_pkg::FUNC_MSB:dword_unit_pkg::FUNC_LSB];
  assign q_shc  = {1'b0, q_req_reg.instr[dword_unit_pkg::SHC_MSB:dword_unit_pkg::SHC_LSB]};

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_sync_n);

  // Legal subtract that overflows
  sequence seq_trap_sub_issue;
    hit && is_sub && legal && field_ok
      && (req.a_val[63] != req.b_val[63]) && (diff[63] != req.a_val[63]);
  endsequence

  // Exception answer without write-back
  sequence seq_trap_answer;
    answer.done && answer.ovf_exc && !answer.wb_en;
  endsequence

  AST_LEFT_BY_REG: assert property ( // [RQ1]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_BY_REG)
      |-> answer.wb_en && (answer.wb_data == (q_req_reg.b_val << q_req_reg.a_val[5:0])))
    else $error("left shift by register gave wrong result");

  AST_LEFT_PLUS32: assert property ( // [RQ2]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_LEFT_LOGICAL_PLUS_THIRTYTWO)
      |-> answer.wb_en && (answer.wb_data == (q_req_reg.b_val << (q_shc + 6'd32))))
    else $error("left shift plus thirty-two gave wrong result");

  AST_RIGHT_ARITH_FIXED: assert property ( // [RQ3]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_FIXED)
      |-> answer.wb_data == 64'($signed(q_req_reg.b_val) >>> q_shc))
    else $error("fixed arithmetic right shift gave wrong result");

  AST_RIGHT_ARITH_REG: assert property ( // [RQ4]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_BY_REG)
      |-> answer.wb_data == 64'($signed(q_req_reg.b_val) >>> q_req_reg.a_val[5:0]))
    else $error("arithmetic right shift by register gave wrong result");

  AST_RIGHT_ARITH_PLUS32: assert property ( // [RQ5]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_ARITH_PLUS_THIRTYTWO)
      |-> answer.wb_data == 64'($signed(q_req_reg.b_val) >>> (q_shc + 6'd32)))
    else $error("arithmetic right shift plus thirty-two gave wrong result");

  AST_RIGHT_LOGIC_FIXED: assert property ( // [RQ6]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_FIXED)
      |-> answer.wb_data == (q_req_reg.b_val >> q_shc))
    else $error("fixed logical right shift gave wrong result");

  AST_RIGHT_LOGIC_REG: assert property ( // [RQ7]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_BY_REG)
      |-> answer.wb_data == (q_req_reg.b_val >> q_req_reg.a_val[5:0]))
    else $error("logical right shift by register gave wrong result");

  AST_RIGHT_LOGIC_PLUS32: assert property ( // [RQ8]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_RIGHT_LOGICAL_PLUS_THIRTYTWO)
      |-> answer.wb_data == (q_req_reg.b_val >> (q_shc + 6'd32)))
    else $error("logical right shift plus thirty-two gave wrong result");

  AST_SUB_RESULT: assert property ( // [RQ9]
    q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_MINUS_WITH_TRAP) && !answer.ovf_exc
      |-> answer.wb_en && (answer.wb_data == (q_req_reg.a_val - q_req_reg.b_val)))
    else $error("subtract gave wrong difference");

  AST_SUB_OVF_RAISE: assert property ( // [RQ10]
    seq_trap_sub_issue |=> answer.ovf_exc)
    else $error("overflowing subtract did not raise overflow");

  AST_SUB_OVF_NOWRITE: assert property ( // [RQ11]
    seq_trap_sub_issue |=> seq_trap_answer ##0 $stable(answer.wb_data))
    else $error("overflowing subtract wrote back or changed result");

  // Overflow pulse only ever answers a legal subtract of the cycle before
  AST_OVF_SOURCE: assert property ( // [RQ10]
    answer.ovf_exc |-> q_ok_reg && (q_func == dword_unit_pkg::FN_DWORD_MINUS_WITH_TRAP))
    else $error("overflow raised without a legal subtract");

  AST_MODE_RESERVED: assert property ( // [RQ12]
    hit && !req.mode64 && !req.kernel |=> answer.rsv_exc && !answer.ovf_exc)
    else $error("user or supervisor 32-bit issue not reserved");

  AST_FIELD_RESERVED: assert property ( // [RQ13]
    hit && is_fixed && (a_idx != dword_unit_pkg::ZERO_FIELD) |=> answer.rsv_exc)
    else $error("nonzero required field not reserved");

  AST_RESERVED_NOWRITE: assert property ( // [RQ14]
    answer.rsv_exc |-> answer.done && !answer.wb_en && $stable(answer.wb_data))
    else $error("reserved instruction wrote back");

endmodule : dword_shift_subtract_unit

//--- design/dword_unit_pkg.sv
// Package: encodings, field positions and carrier structs of the doubleword shift/subtract unit
package dword_unit_pkg;

  // ************************************************************
  // Instruction field positions
  // ************************************************************
  localparam int OPC_MSB   = 31;  // Major opcode
  localparam int OPC_LSB   = 26;
  localparam int OPA_MSB   = 25;  // operand_a_index
  localparam int OPA_LSB   = 21;
  localparam int OPB_MSB   = 20;  // operand_b_index
  localparam int OPB_LSB   = 16;
  localparam int DST_MSB   = 15;  // Destination index
  localparam int DST_LSB   = 11;
  localparam int SHC_MSB   = 10;  // shift_count_field
  localparam int SHC_LSB   = 6;
  localparam int FUNC_MSB  = 5;   // Function code
  localparam int FUNC_LSB  = 0;
  localparam int VAR_AMT_MSB = 5; // Low bits of operand A used as a count

  // ************************************************************
  // Encodings
  // ************************************************************
  localparam logic [5:0] OPC_REG_GROUP = 6'h00;
  localparam logic [5:0] FN_DWORD_LEFT_LOGICAL_BY_REG         = 6'h14;
  localparam logic [5:0] FN_DWORD_LEFT_LOGICAL_PLUS_THIRTYTWO = 6'h3c;
  localparam logic [5:0] FN_DWORD_RIGHT_ARITH_FIXED           = 6'h3b;
  localparam logic [5:0] FN_DWORD_RIGHT_ARITH_BY_REG          = 6'h17;
  localparam logic [5:0] FN_DWORD_RIGHT_ARITH_PLUS_THIRTYTWO  = 6'h3f;
  localparam logic [5:0] FN_DWORD_RIGHT_LOGICAL_FIXED         = 6'h3a;
  localparam logic [5:0] FN_DWORD_RIGHT_LOGICAL_BY_REG        = 6'h16;
  localparam logic [5:0] FN_DWORD_RIGHT_LOGICAL_PLUS_THIRTYTWO = 6'h3e;
  localparam logic [5:0] FN_DWORD_MINUS_WITH_TRAP             = 6'h2e;

  // ************************************************************
  // Constants and reset values
  // ************************************************************
  localparam logic [4:0]  ZERO_FIELD  = 5'h00;   // Required-zero field value
  localparam logic [63:0] ONE64       = 64'h0001; // Carry-in of the subtract
  localparam logic [1:0]  RST_PIPE_INIT = 2'h0;   // Reset synchroniser value in reset

  // ************************************************************
  // Carrier structs
  // ************************************************************
  // Issue from the pipeline
  typedef struct packed {
    logic        valid;   // Instruction presented this cycle
    logic [31:0] instr;   // Instruction word
    logic [63:0] a_val;   // Value read from general_register_file at operand_a_index
    logic [63:0] b_val;   // Value read from general_register_file at operand_b_index
    logic        mode64;  // Core in 64-bit mode
    logic        kernel;  // Core in kernel mode
  } issue_s;

  // Answer towards write-back and exception logic
  typedef struct packed {
    logic        done;     // One-cycle pulse: an instruction of this unit retired
    logic        wb_en;    // Write wb_data to wb_index
    logic [4:0]  wb_index; // Destination index
    logic [63:0] wb_data;  // Result value
    logic        ovf_exc;  // Integer overflow exception
    logic        rsv_exc;  // Reserved instruction exception
  } answer_s;

  localparam answer_s ANSWER_RESET = '0;

endpackage : dword_unit_pkg

//--- design/dword_shifter.sv
// Combinational 64-bit barrel shifter: left logical, right logical, right arithmetic
`timescale 1ns/100ps
module dword_shifter #(
  parameter int WIDTH = 64
) (
  input  wire logic [WIDTH-1:0]         data,
  input  wire logic [$clog2(WIDTH)-1:0] amount,
  input  wire logic                     right,
  input  wire logic                     arith,
  output logic      [WIDTH-1:0]         result
);

  // ************************************************************
  // Shift selection
  // ************************************************************
  // Right shifts fill from the top with zeros or the sign, left fills zeros
  always_comb begin
    if (!right) begin
      result = data << amount;
    end else if (arith) begin
      result = WIDTH'($signed(data) >>> amount);
    end else begin
      result = data >> amount;
    end
  end

endmodule : dword_shifter

//--- verification/issue_pipe_model.sv
// Pipeline-side model: register file read ports for issue and write-back of answers
`timescale 1ns/100ps
module issue_pipe_model (
  input  wire logic                    mclk,
  input  wire logic                    issue_valid,
  input  wire logic [31:0]             issue_instr,
  input  wire logic                    mode64,
  input  wire logic                    kernel,
  input  wire dword_unit_pkg::answer_s answer,
  output dword_unit_pkg::issue_s       req
);
  // ************************************************************
  // Register file
  // ************************************************************
  logic [63:0] regs [32];  // General register contents, seeded by the bench
  logic [63:0] a_read;     // Operand A read port
  logic [63:0] b_read;     // Operand B read port

  // Read ports; idle cycles show inverted data so a stale value never passes
  always_comb begin
    a_read = regs[issue_instr[dword_unit_pkg::OPA_MSB:dword_unit_pkg::OPA_LSB]];
    b_read = regs[issue_instr[dword_unit_pkg::OPB_MSB:dword_unit_pkg::OPB_LSB]];
    req.valid  = issue_valid;
    req.instr  = issue_instr;
    req.a_val  = issue_valid ? a_read : ~a_read;
    req.b_val  = issue_valid ? b_read : ~b_read;
    req.mode64 = mode64;
    req.kernel = kernel;
  end

  // Write-back port: only a granted write changes the file
  always @(posedge mclk) begin
    if (answer.wb_en === 1'b1) begin
      regs[answer.wb_index] <= answer.wb_data;
    end
  end
endmodule : issue_pipe_model

//--- verification/tb_top.sv
// Testbench: directed and random instructions checked against a behavioural model
`timescale 1ns/100ps
module tb_top;
  logic                    mclk;         // Core clock
  logic                    rst_n;        // Core reset, active low
  logic                    issue_valid;  // Issue strobe towards the model
  logic [31:0]             issue_instr;  // Instruction word
  logic                    mode64;       // 64-bit mode level
  logic                    kernel;       // Kernel mode level
  dword_unit_pkg::issue_s  req;          // Issue carrier
  dword_unit_pkg::answer_s answer;       // Answer carrier
  int                      fails;        // Mismatch count
  int                      checks;       // Comparison count
  int                      cycles;       // Clock cycles run
  logic [63:0]             seed;         // Random generator state
  logic                    e_done, e_wr, e_ovf, e_rsv;  // Expected flags of last issue
  logic [4:0]              e_index;      // Expected destination index
  logic [63:0]             e_data;       // Expected result register
  logic [5:0]              fns [9] = '{6'h14, 6'h3c, 6'h3b, 6'h17, 6'h3f, 6'h3a, 6'h16,
                                       6'h3e, 6'h2e};  // All handled function codes

  dword_shift_subtract_unit dword_shift_subtract_unit_inst (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .req    (req),
    .answer (answer)
  );
  issue_pipe_model model_inst (
    .mclk        (mclk),
    .issue_valid (issue_valid),
    .issue_instr (issue_instr),
    .mode64      (mode64),
    .kernel      (kernel),
    .answer      (answer),
    .req         (req)
  );

  // ************************************************************
  // Clock, timeout and closing
  // ************************************************************
  initial mclk = 1'b0;
  always #10 mclk = ~mclk;

  // Cuts a hang short well above the planned run length
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [63:0] rnd();
    seed = {seed[62:0], seed[63] ^ seed[62] ^ seed[60] ^ seed[59]};
    return seed;
  endfunction : rnd

  function automatic logic [31:0] mk(logic [5:0] fn, logic [4:0] ra, logic [4:0] rb,
                                     logic [4:0] rd, logic [4:0] sa);
    return {6'h00, ra, rb, rd, sa, fn};
  endfunction : mk

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // Behavioural model of one issue, from the operands the design really sees
  task automatic predict(input logic [31:0] ins, input logic [63:0] a, input logic [63:0] b);
    logic [5:0]  fn;
    logic [4:0]  sa;
    logic        fixedf;
    logic        varf;
    longint      sb;
    logic [63:0] res;
    fn = ins[5:0];
    sa = ins[10:6];
    sb = b;
    fixedf = fn inside {6'h3c, 6'h3b, 6'h3f, 6'h3a, 6'h3e};
    varf = fn inside {6'h14, 6'h17, 6'h16, 6'h2e};
    e_done = issue_valid && ins[31:26] == 6'h00 && (fixedf || varf);
    e_rsv = e_done && ((!mode64 && !kernel) || (fixedf && ins[25:21] != 5'h00)
            || (varf && sa != 5'h00));
    case (fn)
      6'h14: res = b << a[5:0];
      6'h3c: res = b << (32 + sa);
      6'h3b: res = sb >>> sa;
      6'h17: res = sb >>> a[5:0];
      6'h3f: res = sb >>> (32 + sa);
      6'h3a: res = b >> sa;
      6'h16: res = b >> a[5:0];
      6'h3e: res = b >> (32 + sa);
      default: res = a - b;
    endcase
    e_ovf = e_done && !e_rsv && fn == 6'h2e && a[63] != b[63] && res[63] != a[63];
    e_wr = e_done && !e_rsv && !e_ovf;
    if (e_done) e_index = ins[15:11];
    if (e_wr) e_data = res;
  endtask : predict

  // Checks the answer to the last issue, then issues the next one
  task automatic step(input logic v, input logic [31:0] ins, input logic m64, input logic krn);
    chk("done", 64'(answer.done), 64'(e_done));         // Taken
    chk("wb_en", 64'(answer.wb_en), 64'(e_wr));         // Write
    chk("ovf_exc", 64'(answer.ovf_exc), 64'(e_ovf));    // Overflow
    chk("rsv_exc", 64'(answer.rsv_exc), 64'(e_rsv));    // Reserved
    chk("wb_index", 64'(answer.wb_index), 64'(e_index)); // Index
    chk("wb_data", answer.wb_data, e_data); // Result
    issue_valid = v;
    issue_instr = ins;
    mode64 = m64;
    kernel = krn;
    #1;
    predict(ins, req.a_val, req.b_val);
    @(posedge mclk);
    #1;
  endtask : step

  // Asynchronous reset, then release to the first legal issue edge
  task automatic do_reset();
    rst_n = 1'b0;
    issue_valid = 1'b0;
    #1;
    chk("reset_clear", 64'(answer === dword_unit_pkg::ANSWER_RESET), 64'h0000_0000_0000_0001);
    {e_done, e_wr, e_ovf, e_rsv} = 4'h0;
    e_index = 5'h00;
    e_data = 64'h0000_0000_0000_0000;
    repeat (4) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    repeat (2) @(posedge mclk);
    #1;
  endtask : do_reset

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [63:0] r;
    logic [31:0] ins;
    logic        fx;
    fails = 0;
    checks = 0;
    cycles = 0;
    seed = 64'h0000_0000_0000_0032;
    issue_instr = 32'h0000_0000;
    mode64 = 1'b1;
    kernel = 1'b0;
    for (int i = 0; i < 32; i++) model_inst.regs[i] = rnd();
    // Lets every process reach its first wait so the reset edge is seen
    #1;
    do_reset();
    // Every handled code with count boundaries and sign patterns, back to back
    for (int i = 0; i < 9; i++) begin
      for (int k = 0; k < 4; k++) begin
        fx = fns[i] inside {6'h3c, 6'h3b, 6'h3f, 6'h3a, 6'h3e};
        model_inst.regs[1] = k[0] ? 64'hffff_ffff_ffff_ffff : 64'h0000_0000_0000_0040;
        model_inst.regs[2] = k[1] ? 64'h8000_0000_0000_0001 : 64'h7fff_0000_0000_8000;
        step(1'b1, mk(fns[i], fx ? 5'h00 : 5'h01, 5'h02, 5'(k + 3),
             (fx && k[0]) ? 5'h1f : 5'h00), 1'b1, 1'b0);
      end
    end
    // Overflow operand pairs in all four mode combinations
    for (int p = 0; p < 3; p++) begin
      for (int m = 0; m < 4; m++) begin
        model_inst.regs[1] = (p == 1) ? 64'h7fff_ffff_ffff_ffff :
                             (p == 0) ? 64'h8000_0000_0000_0000 : 64'h0000_0000_0000_0000;
        model_inst.regs[2] = (p == 1) ? 64'hffff_ffff_ffff_ffff :
                             (p == 0) ? 64'h0000_0000_0000_0001 : 64'h8000_0000_0000_0000;
        step(1'b1, mk(6'h2e, 5'h01, 5'h02, 5'h09, 5'h00), m[1], m[0]);
      end
    end
    // Required-zero fields set, then codes this unit must ignore
    for (int i = 0; i < 9; i++) step(1'b1, mk(fns[i], 5'h01, 5'h02, 5'h0a, 5'h01), 1'b1, 1'b1);
    step(1'b1, mk(6'h38, 5'h00, 5'h02, 5'h0b, 5'h03), 1'b1, 1'b0);
    step(1'b1, mk(6'h2f, 5'h01, 5'h02, 5'h0b, 5'h00), 1'b1, 1'b0);
    step(1'b1, mk(6'h2e, 5'h01, 5'h02, 5'h0b, 5'h00) | 32'h0400_0000, 1'b1, 1'b0);
    step(1'b0, mk(6'h2e, 5'h01, 5'h02, 5'h0b, 5'h00), 1'b1, 1'b0);
    // Checks that the idle issue above was ignored
    step(1'b0, 32'h0000_0000, 1'b1, 1'b0);
    do_reset();
    // Random traffic with random operands and modes
    for (int n = 0; n < 400; n++) begin
      r = rnd();
      ins = rnd();
      fx = r[3:0] inside {4'h1, 4'h2, 4'h4, 4'h5, 4'h7};
      ins[31:26] = (r[7:5] == 3'h0) ? 6'h01 : 6'h00;
      ins[5:0] = (r[3:0] < 4'h9) ? fns[r[3:0]] : (r[4] ? 6'h2f : 6'h38);
      if (r[9:8] != 2'h0 && fx) ins[25:21] = 5'h00;
      if (r[9:8] != 2'h0 && !fx) ins[10:6] = 5'h00;
      if (r[12]) model_inst.regs[ins[25:21]] = rnd();
      step(r[20:18] != 3'h0, ins, r[13] | r[15], r[14]);
    end
    step(1'b0, 32'h0000_0000, 1'b1, 1'b0);
    wrap_up();
  end
endmodule : tb_top
